// [jeh_pkg.sv]
// package of constants and carriers, plus the two-flop synchroniser
package jeh_pkg;
	// instruction register
	localparam int IR_W = 5;
	localparam logic [4:0] INS_EXTEST = 5'h00;
	localparam logic [4:0] INS_ID = 5'h01;
	localparam logic [4:0] INS_SAMPLE = 5'h02;
	localparam logic [4:0] INS_DOMRST = 5'h0C;
	localparam logic [4:0] INS_ERASE = 5'h0F;
	localparam logic [4:0] INS_HALT = 5'h1C;
	localparam logic [4:0] INS_BYPASS = 5'h1F;
	// identification layout
	localparam int ID_W = 32;
	localparam int ID_REV_LSB = 28;
	localparam int ID_PART_LSB = 12;
	localparam int ID_MAN_LSB = 1;
	localparam logic ID_MARK = 1'b1;
	// boundary cells per pin
	localparam int BS_CELLS = 3;
	localparam int BS_IN = 0;
	localparam int BS_OUT = 1;
	localparam int BS_OE = 2;
	// reset values
	localparam logic HALT_RST = 1'b0;
	localparam logic BUSY_RST = 1'b0;
	// least idle time after a reset-register write, in test clocks
	localparam int DOMRST_IDLE_TCK = 10;
	// test clock side to system side
	typedef struct packed {
		logic erase_sel;
		logic halt;
	} jeh_ctl_t;
	// system side to test clock side
	typedef struct packed {
		logic busy;
		logic halted;
		logic prot;
		logic flash_rst;
	} jeh_stat_t;
endpackage

`timescale 1ns/1ps
// two-flop level synchroniser with clock enable
module jeh_sync #(
	parameter int W = 1
) (
	// clocking
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '0;
			q <= '0;
		end else if (en) begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule

// [jeh_tap.sv]
// test access port with erase, halt, identification, domain reset and boundary scan
`timescale 1ns/1ps
module jeh_tap #(
	parameter bit HAS_NVM = 1'b1,
	parameter int N_DOM = 1,
	parameter int DOM_SYS = 0,
	parameter int N_PINS = 4,
	parameter logic [3:0] REVISION = 4'h0,
	parameter logic [15:0] PART_NUM = 16'h1234, // arbitrary value
	parameter logic [10:0] MAKER_ID = 11'h2AA // arbitrary value
) (
	// system clock domain
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// test port, all on tck
	input wire logic tck,
	input wire logic tap_rst,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	// nonvolatile memory controller
	output logic erase_req,
	input wire logic erase_done,
	input wire logic prot_set,
	input wire logic flash_in_reset,
	// cpu
	output logic cpu_halt,
	input wire logic cpu_halted,
	// reset domains
	output logic [N_DOM-1:0] dom_reset,
	output logic sys_reset,
	// boundary scan
	input wire logic [N_PINS-1:0] pin_in,
	output logic [N_PINS-1:0] pin_out,
	output logic [N_PINS-1:0] pin_oe,
	input wire logic [N_PINS-1:0] core_out,
	input wire logic [N_PINS-1:0] core_oe,
	output logic [N_PINS-1:0] core_in
);
	localparam int BSW = jeh_pkg::BS_CELLS * N_PINS;
	localparam int DRW = (BSW > jeh_pkg::ID_W) ? ((BSW > N_DOM) ? BSW : N_DOM) :
		((jeh_pkg::ID_W > N_DOM) ? jeh_pkg::ID_W : N_DOM);

	// refuse shapes the logic cannot serve
	if (N_DOM < 1 || N_PINS < 1 || DOM_SYS < 0 || DOM_SYS >= N_DOM) begin : g_chk
		$error("jeh_tap: bad domain or pin count");
	end

	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} jeh_tap_st_t;

	jeh_tap_st_t st_q, st_d;
	logic [4:0] ir_q, ir_d;
	logic [4:0] irsr_q, irsr_d;
	logic [DRW-1:0] drsr_q, drsr_d;
	logic halt_q, halt_d;
	logic [N_DOM-1:0] rreg_q, rreg_d;
	logic [BSW-1:0] bs_q, bs_d;
	logic esel_q, esel_d;
	logic tdo_q, tdo_oe_q;
	jeh_pkg::jeh_stat_t stat_c, stat_t;
	jeh_pkg::jeh_ctl_t ctl_t, ctl_c;
	logic [BSW-1:0] obs_raw, obs_t;
	logic [N_DOM-1:0] rreg_c;
	logic busy_q, busy_d;
	logic esel_seen_q, esel_seen_d;
	logic erase_start;
	logic extest;
	localparam int ID_W_L = jeh_pkg::ID_W;
	logic [ID_W_L-1:0] id_val;

	// selected data register length
	function automatic int dr_len(input logic [4:0] ins);
		case (ins)
			jeh_pkg::INS_ID: dr_len = jeh_pkg::ID_W;
			jeh_pkg::INS_DOMRST: dr_len = N_DOM;
			jeh_pkg::INS_EXTEST, jeh_pkg::INS_SAMPLE: dr_len = BSW;
			default: dr_len = 1;
		endcase
	endfunction

	// identification value
	assign id_val = {REVISION, PART_NUM, MAKER_ID, jeh_pkg::ID_MARK};

	// pin, core-drive and status levels brought onto tck
	always_comb begin
		for (int i = 0; i < N_PINS; i++) begin
			obs_raw[jeh_pkg::BS_CELLS*i+jeh_pkg::BS_IN] = pin_in[i];
			obs_raw[jeh_pkg::BS_CELLS*i+jeh_pkg::BS_OUT] = core_out[i];
			obs_raw[jeh_pkg::BS_CELLS*i+jeh_pkg::BS_OE] = core_oe[i];
		end
	end

	jeh_sync #(.W(BSW)) u_obs_sync (
		.clk(tck),
		.rst(tap_rst),
		.en(1'b1),
		.d(obs_raw),
		.q(obs_t)
	);

	assign stat_c.busy = busy_q;
	assign stat_c.halted = cpu_halted;
	assign stat_c.prot = prot_set;
	assign stat_c.flash_rst = flash_in_reset;

	jeh_sync #(.W($bits(jeh_pkg::jeh_stat_t))) u_stat_sync (
		.clk(tck),
		.rst(tap_rst),
		.en(1'b1),
		.d(stat_c),
		.q(stat_t)
	);

	// tap state walk and scan actions
	always_comb begin
		st_d = st_q;
		ir_d = ir_q;
		irsr_d = irsr_q;
		drsr_d = drsr_q;
		halt_d = halt_q;
		rreg_d = rreg_q;
		bs_d = bs_q;
		case (st_q)
			TLR: st_d = tms ? TLR : RTI;
			RTI: st_d = tms ? SEL_DR : RTI;
			SEL_DR: st_d = tms ? SEL_IR : CAP_DR;
			CAP_DR: st_d = tms ? EX1_DR : SH_DR;
			SH_DR: st_d = tms ? EX1_DR : SH_DR;
			EX1_DR: st_d = tms ? UPD_DR : PA_DR;
			PA_DR: st_d = tms ? EX2_DR : PA_DR;
			EX2_DR: st_d = tms ? UPD_DR : SH_DR;
			UPD_DR: st_d = tms ? SEL_DR : RTI;
			SEL_IR: st_d = tms ? TLR : CAP_IR;
			CAP_IR: st_d = tms ? EX1_IR : SH_IR;
			SH_IR: st_d = tms ? EX1_IR : SH_IR;
			EX1_IR: st_d = tms ? UPD_IR : PA_IR;
			PA_IR: st_d = tms ? EX2_IR : PA_IR;
			EX2_IR: st_d = tms ? UPD_IR : SH_IR;
			UPD_IR: st_d = tms ? SEL_DR : RTI;
			default: st_d = TLR;
		endcase
		case (st_q)
			TLR: ir_d = jeh_pkg::INS_ID;
			CAP_IR: begin
				// p0b01, busy only while erase is the instruction
				irsr_d = {stat_t.prot, 1'b0, (ir_q == jeh_pkg::INS_ERASE) & stat_t.busy,
					1'b0, 1'b1};
			end
			SH_IR: irsr_d = {tdi, irsr_q[4:1]};
			UPD_IR: begin
				ir_d = irsr_q;
			end
			CAP_DR: begin
				drsr_d = '0;
				case (ir_q)
					jeh_pkg::INS_ID: begin
						if (!stat_t.flash_rst) begin
							drsr_d[jeh_pkg::ID_W-1:0] = id_val;
						end
					end
					jeh_pkg::INS_HALT: drsr_d[0] = stat_t.halted;
					jeh_pkg::INS_DOMRST: drsr_d[N_DOM-1:0] = rreg_q;
					jeh_pkg::INS_EXTEST, jeh_pkg::INS_SAMPLE: drsr_d[BSW-1:0] = obs_t;
					default: drsr_d[0] = 1'b0;
				endcase
			end
			SH_DR: begin
				drsr_d = drsr_q >> 1;
				drsr_d[dr_len(ir_q)-1] = tdi;
			end
			UPD_DR: begin
				case (ir_q)
					jeh_pkg::INS_HALT: halt_d = drsr_q[0];
					jeh_pkg::INS_DOMRST: rreg_d = drsr_q[N_DOM-1:0];
					jeh_pkg::INS_EXTEST, jeh_pkg::INS_SAMPLE: bs_d = drsr_q[BSW-1:0];
					default: ;
				endcase
			end
			default: ;
		endcase
		// erase selection level as a flop, so its decode cannot glitch into the sync
		esel_d = (ir_d == jeh_pkg::INS_ERASE);
	end

	// tck registers; only the test reset clears them, never the system reset
	always_ff @(posedge tck) begin
		if (tap_rst) begin
			st_q <= TLR;
			ir_q <= jeh_pkg::INS_ID;
			irsr_q <= '0;
			drsr_q <= '0;
			halt_q <= jeh_pkg::HALT_RST;
			rreg_q <= '0;
			bs_q <= '0;
			esel_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ir_q <= ir_d;
			irsr_q <= irsr_d;
			drsr_q <= drsr_d;
			halt_q <= halt_d;
			rreg_q <= rreg_d;
			bs_q <= bs_d;
			esel_q <= esel_d;
		end
	end

	// tdo changes on the falling edge so the master samples it on the rise
	always_ff @(negedge tck) begin
		if (tap_rst) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_q <= (st_q == SH_IR) ? irsr_q[0] : drsr_q[0];
			tdo_oe_q <= (st_q == SH_IR) || (st_q == SH_DR);
		end
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;

	// pad multiplexers; core always sees the pad level
	assign extest = (ir_q == jeh_pkg::INS_EXTEST);
	always_comb begin
		for (int i = 0; i < N_PINS; i++) begin
			pin_out[i] = extest ? bs_q[jeh_pkg::BS_CELLS*i+jeh_pkg::BS_OUT] : core_out[i];
			pin_oe[i] = extest ? bs_q[jeh_pkg::BS_CELLS*i+jeh_pkg::BS_OE] : core_oe[i];
		end
	end
	assign core_in = pin_in;

	// control levels, including the erase selection level, onto the system clock
	assign ctl_t.erase_sel = esel_q;
	assign ctl_t.halt = halt_q;

	jeh_sync #(.W($bits(jeh_pkg::jeh_ctl_t))) u_ctl_sync (
		.clk(core_clk),
		.rst(rst),
		.en(clk_en),
		.d(ctl_t),
		.q(ctl_c)
	);

	jeh_sync #(.W(N_DOM)) u_rst_sync (
		.clk(core_clk),
		.rst(rst),
		.en(clk_en),
		.d(rreg_q),
		.q(rreg_c)
	);

	assign cpu_halt = ctl_c.halt;
	assign dom_reset = rreg_c;
	assign sys_reset = rreg_c[DOM_SYS];

	// erase busy: a start in the same cycle as done keeps busy set
	// start on the rise of the selection level, so a test reset never restarts it;
	// limitation: the selection must last a few core clocks to be seen
	assign erase_start = ctl_c.erase_sel & ~esel_seen_q;
	always_comb begin
		esel_seen_d = ctl_c.erase_sel;
		busy_d = busy_q;
		if (erase_start && HAS_NVM) begin
			busy_d = 1'b1;
		end else if (erase_done) begin
			busy_d = 1'b0;
		end
		if (!HAS_NVM) begin
			busy_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_q <= jeh_pkg::BUSY_RST;
			esel_seen_q <= 1'b0;
		end else if (clk_en) begin
			busy_q <= busy_d;
			esel_seen_q <= esel_seen_d;
		end
	end

	assign erase_req = busy_q;
endmodule

// [jeh_tap_sva.sv]
// assertions on the ports of the test port block
`timescale 1ns/1ps
module jeh_tap_sva #(
	parameter bit HAS_NVM = 1'b1,
	parameter int N_DOM = 1,
	parameter int DOM_SYS = 0,
	parameter int N_PINS = 4
) (
	// clocks and resets
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tap_rst,
	// watched signals
	input wire logic tdo_oe,
	input wire logic erase_req,
	input wire logic erase_done,
	input wire logic cpu_halt,
	input wire logic [N_DOM-1:0] dom_reset,
	input wire logic sys_reset,
	input wire logic [N_PINS-1:0] pin_in,
	input wire logic [N_PINS-1:0] pin_out,
	input wire logic [N_PINS-1:0] pin_oe,
	input wire logic [N_PINS-1:0] core_out,
	input wire logic [N_PINS-1:0] core_oe,
	input wire logic [N_PINS-1:0] core_in
);
	// core side relations
	a_sys_follow: assert property (@(posedge core_clk) disable iff (rst)
		sys_reset == dom_reset[DOM_SYS]) else $error("system reset bit differs");
	a_nvm_none: assert property (@(posedge core_clk) disable iff (rst)
		!HAS_NVM |-> !erase_req) else $error("erase busy without memory");
	a_busy_hold: assert property (@(posedge core_clk) disable iff (rst)
		erase_req && !erase_done |=> erase_req) else $error("busy dropped early");
	a_busy_end: assert property (@(posedge core_clk) disable iff (rst)
		erase_req && erase_done |=> !erase_req) else $error("busy stuck after done");
	a_done_drop: assert property (@(posedge core_clk) disable iff (rst)
		$fell(erase_req) |-> $past(erase_done)) else $error("busy fell without done");
	a_core_in: assert property (@(posedge core_clk) disable iff (rst)
		core_in == pin_in) else $error("pin input not passed to core");
	// test clock side, tdo_oe is launched on the falling edge
	a_tdo_rst: assert property (@(negedge tck)
		tap_rst |-> ##2 !tdo_oe) else $error("scan out driven in reset");
	a_tap_clear: assert property (@(posedge tck)
		tap_rst [*4] |-> !cpu_halt && dom_reset == '0) else $error("reset left regs set");
	a_pad_pass: assert property (@(posedge tck)
		tap_rst [*2] |-> pin_out == core_out && pin_oe == core_oe) else $error("pads not core");
endmodule

// [jeh_flash_cpu.sv]
// model of the memory controller and cpu behind the port
`timescale 1ns/1ps
module jeh_flash_cpu (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// requests from the port
	input wire logic erase_req,
	input wire logic cpu_halt,
	// status back to the port
	output logic erase_done,
	output logic prot_set,
	output logic cpu_halted
);
	int cnt;
	// erase takes a long spell so busy is seen more than once
	always @(posedge core_clk) begin
		erase_done <= 1'b0;
		cpu_halted <= cpu_halt;
		cnt <= (erase_req && !erase_done) ? cnt + 1 : 0;
		if (rst) begin
			prot_set <= 1'b1;
			cnt <= 0;
		end else if (cnt == 40) begin
			erase_done <= 1'b1;
			prot_set <= 1'b0;
		end
	end
endmodule

// [jeh_tap_bench.sv]
// self-checking bench for the test port block
`timescale 1ns/1ps
module jeh_tap_bench;
	logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, tck = 1'b0, tap_rst = 1'b1;
	logic tms = 1'b0, tdi = 1'b0, flash_in_reset = 1'b0, erase_done, prot_set, cpu_halted;
	logic tdo, tdo_oe, erase_req, cpu_halt, sys_reset;
	logic [0:0] dom_reset;
	logic [3:0] pin_in = 4'hA, core_out = 4'h6, core_oe = 4'h9, pin_out, pin_oe, core_in;
	logic [31:0] c, r;
	int n_mismatch = 0, checks = 0;
	// core clock, and a test clock whose edges never meet a core rising edge
	always #20 core_clk = ~core_clk;
	always #24 tck = ~tck;
	// id values are arbitrary
	jeh_tap #(.REVISION(4'h3), .PART_NUM(16'h5A5A), .MAKER_ID(11'h155)) jeh_tap_inst (
		.core_clk, .rst, .clk_en, .tck, .tap_rst, .tms, .tdi, .tdo, .tdo_oe, .erase_req,
		.erase_done, .prot_set, .flash_in_reset, .cpu_halt, .cpu_halted, .dom_reset,
		.sys_reset, .pin_in, .pin_out, .pin_oe, .core_out, .core_oe, .core_in);
	jeh_flash_cpu jeh_flash_cpu_inst (.core_clk, .rst, .erase_req, .cpu_halt, .erase_done,
		.prot_set, .cpu_halted);
	// one test clock step; tdo is settled since it moves on the falling edge
	task s(input logic m, input logic d);
		@(posedge tck);
		c = {tdo, c[31:1]};
		tms <= m;
		tdi <= d;
	endtask
	// idle to idle scan of n bits, lsb first; captured bits land in r
	task scan(input logic ir, input int n, input logic [31:0] v);
		s(1'b1, 1'b0);
		if (ir) s(1'b1, 1'b0);
		s(1'b0, 1'b0);
		s(1'b0, 1'b0);
		for (int i = 0; i < n; i++) s(i == n - 1, v[i]);
		s(1'b1, 1'b0);
		r = c >> (32 - n);
		s(1'b0, 1'b0);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task wrap_up;
		if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// guard against a hung scan sequence
	initial begin
		#100000;
		n_mismatch++;
		wrap_up;
	end
	// main sequence; waits after writes let values cross both domains
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge tck);
		tap_rst <= 1'b0;
		s(1'b0, 1'b0);
		scan(1'b0, 32, 32'h0);
		chk("identity_select_instruction", {4'h3, 16'h5A5A, 11'h155, 1'b1}, r);
		scan(1'b1, 5, 32'(jeh_pkg::INS_HALT));
		chk("ir_halt", 32'h11, r);
		scan(1'b0, 1, 32'h1);
		repeat (8) s(1'b0, 1'b0);
		scan(1'b0, 1, 32'h1);
		chk("halt_read", 32'h1, r);
		chk("cpu_halt", 32'h1, 32'(cpu_halt));
		scan(1'b1, 5, 32'(jeh_pkg::INS_DOMRST));
		chk("ir_domrst", 32'h11, r);
		scan(1'b0, 1, 32'h1);
		repeat (10) s(1'b0, 1'b0);
		chk("dom_reset", 32'h1, 32'(dom_reset));
		chk("sys_reset", 32'h1, 32'(sys_reset));
		scan(1'b1, 5, 32'(jeh_pkg::INS_ERASE));
		repeat (8) s(1'b0, 1'b0);
		for (int k = 0; k < 40; k++) begin
			scan(1'b1, 5, 32'(jeh_pkg::INS_ERASE));
			if (k == 0) chk("ir_busy", 32'h15, r);
			if (r[2] !== 1'b1) break;
		end
		chk("ir_done", 32'h1, r);
		chk("erase_req", 32'h0, 32'(erase_req));
		scan(1'b0, 1, 32'h1);
		chk("erase_dr", 32'h0, r);
		scan(1'b1, 5, 32'(jeh_pkg::INS_HALT));
		scan(1'b0, 1, 32'h0);
		scan(1'b1, 5, 32'(jeh_pkg::INS_DOMRST));
		scan(1'b0, 1, 32'h0);
		repeat (10) s(1'b0, 1'b0);
		chk("dom_clear", 32'h0, 32'(dom_reset));
		chk("cpu_run", 32'h0, 32'(cpu_halt));
		// flash controller held in reset: identification reads all zero
		flash_in_reset <= 1'b1;
		scan(1'b1, 5, 32'(jeh_pkg::INS_ID));
		scan(1'b0, 32, 32'h0);
		chk("id_flash_rst", 32'h0, r);
		flash_in_reset <= 1'b0;
		// hold the system domain again so the test reset has a bit to clear
		scan(1'b1, 5, 32'(jeh_pkg::INS_DOMRST));
		scan(1'b0, 1, 32'h1);
		repeat (10) s(1'b0, 1'b0);
		scan(1'b1, 5, 32'(jeh_pkg::INS_EXTEST));
		scan(1'b0, 12, 32'h0A6);
		chk("bs_capture", 32'hA9C, r);
		repeat (2) s(1'b0, 1'b0);
		chk("pin_out", 32'h5, 32'(pin_out));
		chk("pin_oe", 32'h3, 32'(pin_oe));
		tap_rst <= 1'b1;
		repeat (5) @(posedge tck);
		tap_rst <= 1'b0;
		s(1'b0, 1'b0);
		chk("pin_rst", 32'h6, 32'(pin_out));
		chk("dom_tap_rst", 32'h0, 32'(dom_reset));
		scan(1'b0, 32, 32'h0);
		chk("identity_select_instruction_again", {4'h3, 16'h5A5A, 11'h155, 1'b1}, r);
		wrap_up;
	end
endmodule
bind jeh_tap jeh_tap_sva #(.HAS_NVM(HAS_NVM), .N_DOM(N_DOM), .DOM_SYS(DOM_SYS),
	.N_PINS(N_PINS)) jeh_tap_sva_inst (.core_clk, .rst, .tck, .tap_rst, .tdo_oe,
	.erase_req, .erase_done, .cpu_halt, .dom_reset, .sys_reset, .pin_in, .pin_out,
	.pin_oe, .core_out, .core_oe, .core_in);
